/* rtl/adc_timing_pkg.sv */
// Purpose: Shared constants and types for the converter clock and sample timing block.
// Assumes: 16-bit registers on a plain strobe port, 40 MHz instruction clock.
// Contract
// - Source select bit 15 set picks the internal RC oscillator as conversion clock.
// - Source select clear derives conversion clock from instruction clock via divider.
// - Bits 12..8 give auto-sample time in conversion clock periods, 0 to 31.
// - Bits 7..0 set conversion clock period; 00111111 gives 64 instruction cycles.
// - Each positive input select field picks the input numbered by its code.
package adc_timing_pkg;

  localparam logic [1:0] ADDR_TIMING_CONFIG   = 2'h0;
  localparam logic [1:0] ADDR_INPUT_MUX_SEL   = 2'h1;
  localparam logic [1:0] ADDR_CONV_STATUS     = 2'h2;

  localparam int SRC_SEL_BIT       = 15;
  localparam int SAMPLE_LSB        = 8;
  localparam int DIV_LSB           = 0;
  localparam int NEG_SECOND_BIT    = 15;
  localparam int POS_SECOND_LSB    = 8;
  localparam int NEG_FIRST_BIT     = 7;
  localparam int POS_FIRST_LSB     = 0;

  localparam logic [15:0] TIMING_WRITE_MASK = 16'h9FFF;
  localparam logic [15:0] MUX_WRITE_MASK    = 16'h9F9F;
  localparam logic [15:0] REG_RESET         = 16'h0000;
  localparam logic [7:0]  DIV_RESERVED_MIN  = 8'h40;

  // Internal RC oscillator stand-in: an enable every RC_DIV_CYCLES clocks.
  localparam int RC_DIV_CYCLES = 4;

  typedef struct packed {
    logic [1:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_s;

  typedef struct packed {
    logic        src_rc;
    logic [4:0]  sample_time;
    logic [7:0]  divider;
  } timing_cfg_s;

  typedef struct packed {
    logic        neg_second;
    logic [4:0]  pos_second;
    logic        neg_first;
    logic [4:0]  pos_first;
  } mux_cfg_s;

endpackage

/* rtl/conv_clock_gen.sv */
// Purpose: Makes the conversion clock as a one-cycle enable pulse.
// Assumes: Single clock domain; the RC source is modelled by a fixed divider.
// Notes: Divider codes of 40h and above are saturated to keep the period bounded.
`timescale 1ns/1ps
`default_nettype none
module conv_clock_gen
  import adc_timing_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       src_rc,
  input  wire logic [7:0] divider,
  output logic            tick
);

  typedef struct packed {
    logic [7:0] cyc_cnt;
    logic [7:0] rc_cnt;
    logic       tick;
  } state_s;

  state_s st;
  state_s next_st;
  logic [7:0] limit;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    // Reserved codes would be software's fault; clamp rather than run away.
    limit = (divider >= DIV_RESERVED_MIN) ? (DIV_RESERVED_MIN - 8'h01) : divider;
    if (src_rc) begin
      next_st.cyc_cnt = 8'h00;
      if (st.rc_cnt == 8'(RC_DIV_CYCLES - 1)) begin
        next_st.rc_cnt = 8'h00;
        next_st.tick = 1'b1;
      end else begin
        next_st.rc_cnt = st.rc_cnt + 8'h01;
      end
    end else begin
      next_st.rc_cnt = 8'h00;
      if (st.cyc_cnt >= limit) begin
        next_st.cyc_cnt = 8'h00;
        next_st.tick = 1'b1;
      end else begin
        next_st.cyc_cnt = st.cyc_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule
`default_nettype wire

/* rtl/sample_timer.sv */
// Purpose: Counts the auto-sample window in conversion clock periods.
// Assumes: start is a one-cycle pulse; tick is the conversion clock enable.
// Notes: A zero sample time ends the window at once, with no sampling period.
`timescale 1ns/1ps
`default_nettype none
module sample_timer
  import adc_timing_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic       tick,
  input  wire logic [4:0] sample_time,
  output logic            sampling,
  output logic            done
);

  typedef struct packed {
    logic [4:0] remain;
    logic       sampling;
    logic       done;
  } state_s;

  state_s st;
  state_s next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (start) begin
      if (sample_time == 5'h00) begin
        next_st.sampling = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.sampling = 1'b1;
        next_st.remain = sample_time;
      end
    end else if (st.sampling && tick) begin
      if (st.remain == 5'h01) begin
        next_st.sampling = 1'b0;
        next_st.done = 1'b1;
      end
      next_st.remain = st.remain - 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sampling = st.sampling;
  assign done     = st.done;

endmodule
`default_nettype wire

/* rtl/adc_clock_sample_timing.sv */
// Purpose: Register file and top level for converter clock and sample timing.
// Assumes: Plain strobe port, read data valid the cycle after the read strobe.
// Notes: Status word shows the live sampling state and a sticky window-done flag.
`timescale 1ns/1ps
`default_nettype none
module adc_clock_sample_timing
  import adc_timing_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [1:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic        sample_start,
  input  wire logic        alt_select,
  output logic [15:0]      rdata,
  output logic             conv_clock_tick,
  output logic             sampling,
  output logic [4:0]       pos_input_sel,
  output logic             neg_input_sel
);

  typedef struct packed {
    timing_cfg_s tcfg;
    mux_cfg_s    mcfg;
    logic        done_seen;
    logic [15:0] rdata;
    logic        tick;
    logic        sampling;
    logic [4:0]  pos_sel;
    logic        neg_sel;
  } state_s;

  state_s   st;
  state_s   next_st;
  bus_req_s req;
  logic     tick_raw;
  logic     samp_raw;
  logic     done_raw;
  logic [15:0] tword;
  logic [15:0] mword;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  conv_clock_gen u_clk (
    .clk     (clk),
    .reset   (reset),
    .src_rc  (st.tcfg.src_rc),
    .divider (st.tcfg.divider),
    .tick    (tick_raw)
  );

  sample_timer u_samp (
    .clk         (clk),
    .reset       (reset),
    .start       (sample_start),
    .tick        (tick_raw),
    .sample_time (st.tcfg.sample_time),
    .sampling    (samp_raw),
    .done        (done_raw)
  );

  always_comb begin
    // Reserved bits 14..13 are never stored, so they always read back as zero.
    tword = {st.tcfg.src_rc, 2'b00, st.tcfg.sample_time, st.tcfg.divider};
    mword = {st.mcfg.neg_second, 2'b00, st.mcfg.pos_second,
             st.mcfg.neg_first, 2'b00, st.mcfg.pos_first};
    next_st = st;
    next_st.rdata = 16'h0000;
    if (req.wr) begin
      case (req.addr)
        ADDR_TIMING_CONFIG: begin
          next_st.tcfg.src_rc      = req.wdata[SRC_SEL_BIT];
          next_st.tcfg.sample_time = req.wdata[SAMPLE_LSB +: 5];
          next_st.tcfg.divider     = req.wdata[DIV_LSB +: 8];
        end
        ADDR_INPUT_MUX_SEL: begin
          next_st.mcfg.neg_second = req.wdata[NEG_SECOND_BIT];
          next_st.mcfg.pos_second = req.wdata[POS_SECOND_LSB +: 5];
          next_st.mcfg.neg_first  = req.wdata[NEG_FIRST_BIT];
          next_st.mcfg.pos_first  = req.wdata[POS_FIRST_LSB +: 5];
        end
        default: begin
        end
      endcase
    end
    // A window end in the same cycle as the clearing read keeps the flag set.
    if (req.rd && req.addr == ADDR_CONV_STATUS) begin
      next_st.done_seen = 1'b0;
    end
    if (done_raw) begin
      next_st.done_seen = 1'b1;
    end
    if (req.rd) begin
      case (req.addr)
        ADDR_TIMING_CONFIG: next_st.rdata = tword & TIMING_WRITE_MASK;
        ADDR_INPUT_MUX_SEL: next_st.rdata = mword & MUX_WRITE_MASK;
        ADDR_CONV_STATUS:   next_st.rdata = {14'h0000, st.done_seen, samp_raw};
        default:            next_st.rdata = 16'h0000;
      endcase
    end
    next_st.tick     = tick_raw;
    next_st.sampling = samp_raw;
    if (alt_select) begin
      next_st.pos_sel = st.mcfg.pos_second;
      next_st.neg_sel = st.mcfg.neg_second;
    end else begin
      next_st.pos_sel = st.mcfg.pos_first;
      next_st.neg_sel = st.mcfg.neg_first;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata           = st.rdata;
  assign conv_clock_tick = st.tick;
  assign sampling        = st.sampling;
  assign pos_input_sel   = st.pos_sel;
  assign neg_input_sel   = st.neg_sel;

endmodule
`default_nettype wire

/* verif/adc_timing_checker.sv */
// Purpose: Checks clock period, window length, mux outputs and reads.
// Assumes: Only the top ports are visible; config is shadowed from writes.
// Notes: Period checks wait more than 140 quiet cycles so a new divider has settled.
`timescale 1ns/1ps
`default_nettype none
module adc_timing_checker
  import adc_timing_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [1:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic        sample_start,
  input wire logic        alt_select,
  input wire logic [15:0] rdata,
  input wire logic        conv_clock_tick,
  input wire logic        sampling,
  input wire logic [4:0]  pos_input_sel,
  input wire logic        neg_input_sel
);
  logic [15:0] cfg_q, mux_q;
  logic [7:0]  quiet, gap;
  logic [11:0] win, per, samp;
  assign per  = cfg_q[15] ? 12'(RC_DIV_CYCLES) : {4'h0, cfg_q[7:0]} + 12'h001;
  assign samp = {7'h00, cfg_q[12:8]};
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_q <= '0;
      mux_q <= '0;
      quiet <= '0;
      gap   <= '0;
      win   <= '0;
    end else begin
      if (wr && addr == ADDR_TIMING_CONFIG) cfg_q <= wdata & TIMING_WRITE_MASK;
      if (wr && addr == ADDR_INPUT_MUX_SEL) mux_q <= wdata & MUX_WRITE_MASK;
      quiet <= (wr && addr == ADDR_TIMING_CONFIG) ? 8'h00 : quiet + 8'(quiet != 8'hFF);
      gap   <= conv_clock_tick ? 8'h01 : gap + 8'(gap != 8'hFF);
      win   <= sampling ? win + 12'h001 : 12'h000;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_rc_period: assert property (conv_clock_tick && quiet > 8'h8C && cfg_q[15]
    |-> gap == 8'(RC_DIV_CYCLES)) else $error("rc tick period wrong");
  chk_div_period: assert property (conv_clock_tick && quiet > 8'h8C && !cfg_q[15]
    && cfg_q[7:0] < DIV_RESERVED_MIN |-> gap == cfg_q[7:0] + 8'h01) else $error("div period");
  chk_div_max: assert property (conv_clock_tick && quiet > 8'h8C && cfg_q[15:0] == 16'h003F
    |-> gap == 8'h40) else $error("period 64 missed");
  chk_window_len: assert property ($fell(sampling) && quiet > 8'h8C && samp != 0
    |-> win >= (samp - 1) * per && win <= samp * per + 2) else $error("window length");
  chk_mux_pos: assert property (!$past(wr) && !$past(wr, 2) && !$past(reset)
    |-> pos_input_sel == ($past(alt_select) ? mux_q[12:8] : mux_q[4:0])) else $error("pos");
  chk_mux_neg: assert property (!$past(wr) && !$past(wr, 2) && !$past(reset)
    |-> neg_input_sel == ($past(alt_select) ? mux_q[15] : mux_q[7])) else $error("neg");
  chk_cfg_read: assert property (rd && addr == ADDR_TIMING_CONFIG
    |=> rdata == cfg_q) else $error("config readback");
  chk_rdata_idle: assert property (!rd |=> rdata == 16'h0000) else $error("rdata not idle");
  cover property (conv_clock_tick && cfg_q[15]);
  cover property ($fell(sampling));
  cover property (alt_select && pos_input_sel != 5'h00);
endmodule
bind adc_clock_sample_timing adc_timing_checker chk (.clk, .reset, .addr, .wdata, .wr, .rd,
  .sample_start, .alt_select, .rdata, .conv_clock_tick, .sampling, .pos_input_sel,
  .neg_input_sel);
`default_nettype wire

/* verif/tb.sv */
// Purpose: Register, clock period, sample window and mux tests.
// Assumes: Read data is looked at one cycle after the read strobe.
// Notes: Window length is bounded, since the first tick phase is free.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import adc_timing_pkg::*;
  logic        clk = 0, reset = 1, wr = 0, rd = 0, sample_start = 0, alt_select = 0;
  logic [1:0]  addr = '0;
  logic [15:0] wdata = '0, rdata;
  logic        conv_clock_tick, sampling, neg_input_sel;
  logic [4:0]  pos_input_sel;
  logic [15:0] cfgs[5] = '{16'h8000, 16'h0000, 16'h0001, 16'h003F, 16'h0005};
  int          pers[5] = '{4, 1, 2, 64, 6};
  int          n_fail = 0, checked = 0, len;
  always #12.5 clk = ~clk;
  adc_clock_sample_timing dut (.clk, .reset, .addr, .wdata, .wr, .rd, .sample_start,
    .alt_select, .rdata, .conv_clock_tick, .sampling, .pos_input_sel, .neg_input_sel);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [1:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp, "rdata");
  endtask
  task automatic wait_on(input bit tick);
    int i;
    for (i = 0; i < 200 && (tick ? conv_clock_tick : sampling) !== 1'b1; i++) step(1);
    if (i == 200) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  task automatic pulse;
    @(posedge clk);
    sample_start <= 1'b1;
    @(posedge clk);
    sample_start <= 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rchk(0, 16'h0000);
    rchk(1, 16'h0000);
    wreg(0, 16'h9F3F);
    rchk(0, 16'h9F3F);
    wreg(1, 16'hFFFF);
    rchk(1, 16'h9F9F);
    rchk(3, 16'h0000);
    foreach (cfgs[k]) begin
      wreg(0, cfgs[k]);
      step(142);
      wait_on(1);
      len = 0;
      do begin
        step(1);
        len++;
      end while (conv_clock_tick !== 1'b1 && len < 200);
      check(16'(len), 16'(pers[k]), "tick period");
    end
    wreg(0, 16'h8300);
    step(142);
    pulse();
    wait_on(0);
    len = 0;
    while (sampling === 1'b1 && len < 300) begin
      step(1);
      len++;
    end
    check({15'h0, len >= 8 && len <= 14}, 16'h0001, "window");
    rchk(2, 16'h0002);
    rchk(2, 16'h0000);
    wreg(0, 16'h8000);
    pulse();
    step(6);
    rchk(2, 16'h0002);
    for (int c = 0; c < 32; c++) begin
      wreg(1, {3'h0, 5'(c), 3'h4, ~5'(c)});
      for (int a = 0; a < 2; a++) begin
        @(posedge clk);
        alt_select <= a[0];
        step(3);
        check({11'h0, pos_input_sel}, {11'h0, a ? 5'(c) : ~5'(c)}, "pos select");
        check({15'h0, neg_input_sel}, {15'h0, a == 0}, "neg select");
      end
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
